// File: rtl/table_read_xor_exec.sv
// Execution unit for bit-skip, table read and XOR instructions.
// Assumes a decoder on sys_clk and a program memory answering with pm_ack.
//
// Overview of operation
// - Bit clear: skip next instruction via a dummy cycle; three cycles.
// - Selected bit one: no skip; zero flag unchanged either way, skip flag cleared.
// - Page read: fetch at page pointer and low pointer; low to memory.
// - Final-page read: fetch in last page by low pointer; low to memory.
// - Incrementing page read: bump low pointer first, then page read.
// - Incrementing final read: bump pointer first; table reads leave flags.
// - XOR into working register: result to accumulator, only zero flag.
// - XOR into memory: result to memory, accumulator unchanged.
`timescale 1ns/1ps
module table_read_xor_exec
  import txe_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [BUS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              instr_valid,
  input  wire logic [2:0]        instr_op,
  input  wire logic [DM_AW-1:0]  instr_mem_addr,
  input  wire logic [2:0]        instr_bit_sel,
  output logic                   instr_ready,
  output logic                   instr_done,
  output logic                   skip_taken,
  output logic                   dummy_cycle,
  output logic                   pm_req,
  output logic      [PM_W-1:0]   pm_addr,
  input  wire logic              pm_ack,
  input  wire logic [PM_W-1:0]   pm_rdata,
  output logic      [DATA_W-1:0] acc_out,
  output logic                   zero_flag
);

  state_t            state_r;
  state_t            state_nxt;
  op_t               op_r;
  logic [DM_AW-1:0]  op_addr_r;
  logic [2:0]        bit_r;
  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] table_low_pointer_r;
  logic [DATA_W-1:0] table_page_pointer_r;
  logic [DATA_W-1:0] table_high_latch_r;
  logic [DM_AW-1:0]  dm_addr_r;
  logic              zero_r;
  logic              skip_r;
  logic [PM_W-1:0]   pm_addr_r;
  logic              ack_r;
  logic              sel_dm_r;
  logic [31:0]       rdata_r;

  dmem_if dm ();

  dmem_ram u_ram (
    .sys_clk (sys_clk),
    .bus     (dm)
  );

  // Decode of state, instruction class and bus access.
  wire idle      = (state_r == ST_IDLE);
  wire in_eval   = (state_r == ST_EVAL);
  wire in_fetch  = (state_r == ST_FETCH);
  wire bus_req   = avs_read | avs_write;
  wire accept    = instr_valid & idle & ~bus_req;
  wire bus_go    = bus_req & idle & ~ack_r;
  wire bus_wr    = ack_r & avs_write;
  op_t op_in;
  assign op_in = op_t'(instr_op);
  wire is_inc    = (op_in == OP_INC_PAGE_TABLE_READ) |
                   (op_in == OP_INC_FINAL_TABLE_READ);
  wire is_final  = (op_in == OP_FINAL_PAGE_TABLE_READ) |
                   (op_in == OP_INC_FINAL_TABLE_READ);
  wire is_table  = is_inc | is_final |
                   (op_in == OP_PAGE_TABLE_READ);

  // Eight-bit add drops the carry, so the page pointer is never touched.
  wire [DATA_W-1:0] low_inc  = table_low_pointer_r + PTR_STEP;
  wire [DATA_W-1:0] low_use  = is_inc ? low_inc : table_low_pointer_r;
  wire [DATA_W-1:0] page_use = is_final ? LAST_PAGE
                                        : table_page_pointer_r;

  wire [DATA_W-1:0] xor_res  = acc_r ^ dm.q;
  wire              xor_zero = (xor_res == RST_BYTE);
  wire              bit_val  = dm.q[bit_r];
  wire              do_skip  = in_eval & (op_r == OP_SKIP_ON_BIT_CLEAR)
                               & ~bit_val;
  wire              xor_acc  = in_eval & (op_r == OP_XOR_INTO_WORKING_REG);
  wire              xor_mem  = in_eval & (op_r == OP_XOR_INTO_MEMORY);
  wire              tbl_done = in_fetch & pm_ack;

  // Register decode.
  wire hit_acc   = (avs_address == OFF_ACC);
  wire hit_stat  = (avs_address == OFF_STATUS);
  wire hit_low   = (avs_address == OFF_LOW_PTR);
  wire hit_page  = (avs_address == OFF_PAGE_PTR);
  wire hit_high  = (avs_address == OFF_HIGH_LATCH);
  wire hit_dma   = (avs_address == OFF_DM_ADDR);
  wire hit_dmd   = (avs_address == OFF_DM_DATA);

  wire [7:0] status_byte = {5'h00, skip_r, ~idle, zero_r};
  wire [7:0] rd_byte = hit_acc  ? acc_r :
                       hit_stat ? status_byte :
                       hit_low  ? table_low_pointer_r :
                       hit_page ? table_page_pointer_r :
                       hit_high ? table_high_latch_r :
                       hit_dma  ? dm_addr_r : 8'h00;

  // Memory port: the bus owns it only while the core is idle.
  assign dm.addr  = idle ? dm_addr_r : op_addr_r;
  assign dm.we    = xor_mem | tbl_done | (bus_wr & hit_dmd);
  assign dm.wdata = in_eval  ? xor_res :
                    in_fetch ? pm_rdata[7:0] :
                               avs_writedata[7:0];

  assign avs_waitrequest = bus_req & ~ack_r;
  assign avs_readdata    = sel_dm_r ? {24'h000000, dm.q} : rdata_r;
  assign instr_ready     = idle & ~bus_req;
  assign instr_done      = (in_eval & ~do_skip) | dummy_cycle | tbl_done;
  assign dummy_cycle     = (state_r == ST_DUMMY);
  assign skip_taken      = skip_r;
  assign pm_req          = in_fetch;
  assign pm_addr         = pm_addr_r;
  assign acc_out         = acc_r;
  assign zero_flag       = zero_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = is_table ? ST_FETCH : ST_READ;
        end
      end
      ST_READ: begin
        state_nxt = ST_EVAL;
      end
      ST_EVAL: begin
        state_nxt = do_skip ? ST_DUMMY : ST_IDLE;
      end
      ST_DUMMY: begin
        state_nxt = ST_IDLE;
      end
      ST_FETCH: begin
        state_nxt = pm_ack ? ST_IDLE : ST_FETCH;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r   <= ST_IDLE;
      op_r      <= OP_NONE;
      op_addr_r <= RST_BYTE;
      bit_r     <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (accept) begin
        op_r      <= op_in;
        op_addr_r <= instr_mem_addr;
        bit_r     <= instr_bit_sel;
      end
    end
  end

  // Pointer bump and fetch address are taken together, so the fetch
  // uses the updated low pointer, already incremented for the incrementing reads.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      table_low_pointer_r <= RST_BYTE;
      pm_addr_r           <= 16'h0000;
    end else if (accept & is_table) begin
      table_low_pointer_r <= low_use;
      pm_addr_r           <= {page_use, low_use};
    end else if (bus_wr & hit_low) begin
      table_low_pointer_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      table_page_pointer_r <= RST_BYTE;
      dm_addr_r            <= RST_BYTE;
      table_high_latch_r   <= RST_BYTE;
    end else begin
      if (bus_wr & hit_page) begin
        table_page_pointer_r <= avs_writedata[7:0];
      end
      if (bus_wr & hit_dma) begin
        dm_addr_r <= avs_writedata[7:0];
      end
      if (tbl_done) begin
        table_high_latch_r <= pm_rdata[15:8];
      end
    end
  end

  // Only the XOR instructions reach the zero flag; skips and table reads
  // leave it alone.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc_r  <= RST_BYTE;
      zero_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      if (xor_acc) begin
        acc_r <= xor_res;
      end else if (bus_wr & hit_acc) begin
        acc_r <= avs_writedata[7:0];
      end
      if (xor_acc | xor_mem) begin
        zero_r <= xor_zero;
      end else if (bus_wr & hit_stat) begin
        zero_r <= avs_writedata[ST_ZERO];
      end
      if (in_eval & (op_r == OP_SKIP_ON_BIT_CLEAR)) begin
        skip_r <= ~bit_val;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_r    <= 1'b0;
      sel_dm_r <= 1'b0;
      rdata_r  <= 32'h00000000;
    end else begin
      ack_r <= bus_go;
      if (bus_go) begin
        sel_dm_r <= hit_dmd;
        rdata_r  <= {24'h000000, rd_byte};
      end
    end
  end

endmodule // table_read_xor_exec

// File: rtl/txe_pkg.sv
// Constants, register map and types for the table read / XOR / bit-skip unit.
// Assumes 8-bit data memory and 16-bit program words on one core clock.
package txe_pkg;

  localparam int DATA_W = 8;
  localparam int PM_W   = 16;
  localparam int DM_AW  = 8;
  localparam int BUS_AW = 5;

  // Register byte offsets on the slave bus.
  localparam logic [BUS_AW-1:0] OFF_ACC        = 5'h00;
  localparam logic [BUS_AW-1:0] OFF_STATUS     = 5'h04;
  localparam logic [BUS_AW-1:0] OFF_LOW_PTR    = 5'h08;
  localparam logic [BUS_AW-1:0] OFF_PAGE_PTR   = 5'h0c;
  localparam logic [BUS_AW-1:0] OFF_HIGH_LATCH = 5'h10;
  localparam logic [BUS_AW-1:0] OFF_DM_ADDR    = 5'h14;
  localparam logic [BUS_AW-1:0] OFF_DM_DATA    = 5'h18;

  // Status register bit positions.
  localparam int ST_ZERO = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_SKIP = 2;

  localparam logic [DATA_W-1:0] RST_BYTE  = 8'h00;
  localparam logic [DATA_W-1:0] LAST_PAGE = 8'hff;
  localparam logic [DATA_W-1:0] PTR_STEP  = 8'h01;

  typedef enum logic [2:0] {
    OP_SKIP_ON_BIT_CLEAR     = 3'h0,
    OP_PAGE_TABLE_READ       = 3'h1,
    OP_FINAL_PAGE_TABLE_READ = 3'h2,
    OP_INC_PAGE_TABLE_READ   = 3'h3,
    OP_INC_FINAL_TABLE_READ  = 3'h4,
    OP_XOR_INTO_WORKING_REG  = 3'h5,
    OP_XOR_INTO_MEMORY       = 3'h6,
    OP_NONE                  = 3'h7
  } op_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_EVAL  = 5'h04,
    ST_DUMMY = 5'h08,
    ST_FETCH = 5'h10
  } state_t;

endpackage

// File: rtl/dmem_if.sv
// Port bundle between the execution unit and its data memory.
// Assumes a single-port memory with registered read data.
`timescale 1ns/1ps
interface dmem_if;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] q;

  modport ctrl (output we, output addr, output wdata, input q);
  modport mem  (input we, input addr, input wdata, output q);
endinterface

// File: rtl/dmem_ram.sv
// Data memory of 256 bytes, one port, synchronous write, registered read.
// Assumes one clock; contents are not cleared by reset.
`timescale 1ns/1ps
module dmem_ram (
  input wire logic sys_clk,
  dmem_if.mem      bus
);

  logic [7:0] mem [0:255];

  // Read returns the old byte when read and write hit the same cycle.
  always_ff @(posedge sys_clk) begin
    if (bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
    bus.q <= mem[bus.addr];
  end

endmodule // dmem_ram

// File: verification/txe_props.sv
// Concurrent checks on the execution unit's instruction side.
// Assumes only the unit's top ports; bound after the module.
`timescale 1ns/1ps
module txe_props
  import txe_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            reset,
  input wire logic            instr_valid,
  input wire logic [2:0]      instr_op,
  input wire logic            instr_ready,
  input wire logic            instr_done,
  input wire logic            skip_taken,
  input wire logic            dummy_cycle,
  input wire logic            pm_req,
  input wire logic            pm_ack,
  input wire logic [PM_W-1:0] pm_addr,
  input wire logic [7:0]      acc_out,
  input wire logic            zero_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [2:0] op_r;
  wire        take = instr_valid && instr_ready;
  wire        fin_op = op_r inside {OP_FINAL_PAGE_TABLE_READ,
                                    OP_INC_FINAL_TABLE_READ};
  always_ff @(posedge sys_clk) begin
    if (reset) op_r <= OP_NONE;
    else if (take) op_r <= instr_op;
  end
  sequence skip_acc;
    take && instr_op == OP_SKIP_ON_BIT_CLEAR;
  endsequence
  sequence fin_read;
    pm_req && fin_op;
  endsequence
  skip_length_a: assert property (
    skip_acc |-> ##3 skip_taken == dummy_cycle)
    else $error("skip result and dummy cycle disagree");
  dummy_done_a: assert property (
    dummy_cycle |-> instr_done && $past(take, 3))
    else $error("dummy cycle not third cycle");
  skip_flags_a: assert property (
    skip_acc |=> $stable(zero_flag) [*3])
    else $error("bit test changed zero flag");
  final_page_a: assert property (
    fin_read |-> pm_addr[15:8] == LAST_PAGE)
    else $error("final page read off last page");
  table_done_a: assert property (
    pm_req && pm_ack |-> instr_done)
    else $error("table read not finished at answer");
  table_flags_a: assert property (
    pm_req |=> $stable(zero_flag))
    else $error("table read changed zero flag");
  xor_zero_a: assert property (
    instr_done && op_r == OP_XOR_INTO_WORKING_REG
    |=> zero_flag == (acc_out == 8'h00))
    else $error("zero flag wrong after xor");
  xor_keep_a: assert property (
    instr_done && op_r == OP_XOR_INTO_MEMORY |=> $stable(acc_out))
    else $error("xor into memory changed accumulator");
endmodule // txe_props
bind table_read_xor_exec txe_props u_props (
  .sys_clk     (sys_clk),
  .reset       (reset),
  .instr_valid (instr_valid),
  .instr_op    (instr_op),
  .instr_ready (instr_ready),
  .instr_done  (instr_done),
  .skip_taken  (skip_taken),
  .dummy_cycle (dummy_cycle),
  .pm_req      (pm_req),
  .pm_ack      (pm_ack),
  .pm_addr     (pm_addr),
  .acc_out     (acc_out),
  .zero_flag   (zero_flag)
);

// File: verification/tb_top.sv
// Self-checking bench driving the unit's bus and instruction ports.
// Assumes the unit alone; the bench plays decoder and program memory.
`timescale 1ns/1ps
module tb_top;
  import txe_pkg::*;
  logic        sys_clk = 1'h0, reset = 1'h1, avs_read = 1'h0;
  logic        avs_write = 1'h0, instr_valid = 1'h0, pm_ack = 1'h0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [2:0]  instr_op = 3'h7, instr_bit_sel = 3'h0;
  logic [7:0]  instr_mem_addr = 8'h00, acc_out, lp, a;
  logic        avs_waitrequest, instr_ready, instr_done, skip_taken;
  logic        dummy_cycle, pm_req, zero_flag, dum;
  logic [15:0] pm_addr, w, pm_rdata = 16'h0000;
  int          fails = 0, total_checks = 0, cyc = 0, lat = 0, pcnt = 0, n;
  always #4 sys_clk = ~sys_clk;
  table_read_xor_exec DUT (
    .sys_clk         (sys_clk),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .instr_valid     (instr_valid),
    .instr_op        (instr_op),
    .instr_mem_addr  (instr_mem_addr),
    .instr_bit_sel   (instr_bit_sel),
    .instr_ready     (instr_ready),
    .instr_done      (instr_done),
    .skip_taken      (skip_taken),
    .dummy_cycle     (dummy_cycle),
    .pm_req          (pm_req),
    .pm_addr         (pm_addr),
    .pm_ack          (pm_ack),
    .pm_rdata        (pm_rdata),
    .acc_out         (acc_out),
    .zero_flag       (zero_flag)
  );
  // Program memory answers lat+1 cycles after pm_req rises with a word tied to its address.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    pcnt <= (pm_req && !pm_ack) ? pcnt + 1 : 0;
    pm_ack <= pm_req && !pm_ack && pcnt >= lat;
    pm_rdata <= pm_addr ^ 16'h5aa5;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] ad,
                     input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic mem(input logic wr, input logic [7:0] m, input logic [7:0] d);
    bus(1'h1, OFF_DM_ADDR, m);
    bus(wr, OFF_DM_DATA, d);
  endtask
  task automatic run(input logic [2:0] op, input logic [7:0] m,
                     input logic [2:0] b);
    @(posedge sys_clk);
    instr_valid <= 1'h1;
    instr_op <= op;
    instr_mem_addr <= m;
    instr_bit_sel <= b;
    do @(posedge sys_clk); while (instr_ready !== 1'h1);
    instr_valid <= 1'h0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      dum = dummy_cycle;
    end while (instr_done !== 1'h1);
    // One more edge so results registered at the done edge have settled.
    @(posedge sys_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'h0;
    mem(1'h1, 8'h10, 8'h0f);
    for (int i = 0; i < 2; i++) begin
      a = (i == 1) ? 8'h0f : 8'h3c;
      bus(1'h1, OFF_ACC, a);
      run(3'h5, 8'h10, 3'h0);
      chk(32'(n), 32'h2);
      bus(1'h0, OFF_ACC, 8'h00);
      chk(q, {24'h0, a ^ 8'h0f});
      bus(1'h0, OFF_STATUS, 8'h00);
      chk(q & 32'h1, {31'h0, i == 1});
    end
    bus(1'h1, OFF_ACC, 8'h55);
    mem(1'h1, 8'h20, 8'h0f);
    run(3'h6, 8'h20, 3'h0);
    mem(1'h0, 8'h20, 8'h00);
    chk(q, 32'h5a);
    chk({24'h0, acc_out}, 32'h55);
    // The no-op code takes the xor timing and changes nothing.
    run(3'h7, 8'h20, 3'h0);
    chk(32'(n), 32'h2);
    chk({24'h0, acc_out}, 32'h55);
    $display("xor tests over");
    bus(1'h1, OFF_STATUS, 8'h01);
    mem(1'h1, 8'h30, 8'h20);
    for (int b = 4; b <= 5; b++) begin
      run(3'h0, 8'h30, 3'(b));
      chk(32'(n), b == 5 ? 32'h2 : 32'h3);
      chk({31'h0, skip_taken}, {31'h0, b == 4});
      chk({31'h0, dum}, {31'h0, b == 4});
      chk({31'h0, zero_flag}, 32'h1);
    end
    $display("skip tests over");
    bus(1'h1, OFF_PAGE_PTR, 8'h3c);
    for (int op = 1; op <= 4; op++) begin
      lat = op;
      bus(1'h1, OFF_LOW_PTR, 8'hff);
      run(3'(op), 8'h40, 3'h0);
      lp = op >= 3 ? 8'h00 : 8'hff;
      w = {(op == 1 || op == 3) ? 8'h3c : 8'hff, lp} ^ 16'h5aa5;
      mem(1'h0, 8'h40, 8'h00);
      chk(q, {24'h0, w[7:0]});
      bus(1'h0, OFF_HIGH_LATCH, 8'h00);
      chk(q, {24'h0, w[15:8]});
      bus(1'h0, OFF_LOW_PTR, 8'h00);
      chk(q, {24'h0, lp});
      bus(1'h0, OFF_PAGE_PTR, 8'h00);
      chk(q, 32'h3c);
      chk({31'h0, zero_flag}, 32'h1);
    end
    bus(1'h1, OFF_HIGH_LATCH, 8'h77);
    bus(1'h0, OFF_HIGH_LATCH, 8'h00);
    chk(q, {24'h0, w[15:8]});
    bus(1'h1, 5'h1c, 8'haa);
    bus(1'h0, 5'h1c, 8'h00);
    chk(q, 32'h0);
    $display("table tests over");
    end_of_test();
  end
endmodule // tb_top
